// *** design/prio_store.sv ***
// Storage for the per-interrupt priority fields, one byte each.
// Assumes a single write port and a registered read port on the same clock.
`timescale 1ns/1ps
module prio_store (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [prio_view_pkg::IDX_W-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [prio_view_pkg::IDX_W-1:0] raddr,
	output logic [7:0] rdata_r
);
	import prio_view_pkg::*;

	logic [7:0] mem [NUM_IRQ];

	// Contents are data, not control, so they carry no reset
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end
endmodule

// *** design/prio_view_pkg.sv ***
// Constants and carrier types for the priority view translation block.
// Assumes one clock domain; every user of the block imports this package.
package prio_view_pkg;

	// Implemented upper bits of each 8-bit priority field
	localparam int PRIO_BITS = 5;
	localparam logic [7:0] PRIO_MASK = 8'hf8; // Bits [7:3] kept, low bits dropped
	// Mask of the shifted view that non-secure accesses see
	localparam logic [7:0] NS_MASK = {PRIO_MASK[6:0], 1'b0};
	localparam int NUM_IRQ = 32;
	localparam int IDX_W = 5;
	localparam logic [7:0] PMR_RST = 8'h00;
	localparam logic [NUM_IRQ-1:0] GRP_RST = 32'h0000_0000; // All group 0 after reset
	localparam int RSP_LAT = 2; // Cycles from request to answer

	typedef enum logic [1:0] {
		TGT_PRIO = 2'h0,
		TGT_GROUP = 2'h1,
		TGT_PMR = 2'h2,
		TGT_RPR = 2'h3
	} target_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic secure;
		target_t tgt;
		logic [IDX_W-1:0] idx;
		logic [7:0] wdata;
	} access_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} access_rsp_t;

endpackage

// *** design/priority_secure_view_logic.sv ***
// Secure and non-secure views of interrupt priorities, mask and running priority.
// Assumes requests come from logic on sys_clk, one per cycle at most.
`timescale 1ns/1ps
module priority_secure_view_logic (
	input wire logic sys_clk,
	input wire logic srst,
	input wire prio_view_pkg::access_req_t req,
	input wire logic [7:0] run_prio,
	output prio_view_pkg::access_rsp_t rsp,
	output logic [7:0] prio_mask,
	output logic [prio_view_pkg::NUM_IRQ-1:0] irq_group
);
	import prio_view_pkg::*;

	logic [NUM_IRQ-1:0] grp_r, grp_nxt;
	logic [7:0] pmr_r, pmr_nxt;
	access_req_t s1_r, s1_nxt;
	logic s1_grp_r, s1_grp_nxt;
	logic [7:0] s1_rpr_r, s1_rpr_nxt;
	access_rsp_t rsp_r, rsp_nxt;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic wr_g1;

	// Stored form of a non-secure write: halved, top forced high
	function automatic logic [7:0] ns_to_store(input logic [7:0] v);
		return {1'b1, v[7:1]} & PRIO_MASK;
	endfunction

	// Non-secure view of a stored value
	function automatic logic [7:0] store_to_ns(input logic [7:0] v);
		return {v[6:0], 1'b0} & NS_MASK;
	endfunction

	assign wr_g1 = grp_r[req.idx];

	// Priority writes: non-secure ones to group 0 are dropped
	always_comb begin
		mem_we = req.valid && req.write && (req.tgt == TGT_PRIO)
			&& (req.secure || wr_g1);
		if (req.secure) begin
			mem_wdata = req.wdata & PRIO_MASK;
		end else begin
			mem_wdata = ns_to_store(req.wdata);
		end
	end

	prio_store u_store (
		.sys_clk(sys_clk),
		.we(mem_we),
		.waddr(req.idx),
		.wdata(mem_wdata),
		.raddr(req.idx),
		.rdata_r(mem_rdata)
	);

	// Group bits only change under secure writes; one bit per interrupt
	for (genvar g = 0; g < NUM_IRQ; g++) begin : g_grp
		always_comb begin
			grp_nxt[g] = grp_r[g];
			if (req.valid && req.write && req.secure && (req.tgt == TGT_GROUP)
				&& (req.idx == IDX_W'(g))) begin
				grp_nxt[g] = req.wdata[0];
			end
		end
	end

	// Mask register: non-secure write ignored while its top bit is clear
	always_comb begin
		pmr_nxt = pmr_r;
		if (req.valid && req.write && (req.tgt == TGT_PMR)) begin
			if (req.secure) begin
				pmr_nxt = req.wdata & PRIO_MASK;
			end else if (pmr_r[7]) begin
				pmr_nxt = ns_to_store(req.wdata);
			end
		end
	end

	// Capture the request so its answer can be built next to the memory output
	always_comb begin
		s1_nxt = req;
		s1_grp_nxt = wr_g1;
		s1_rpr_nxt = run_prio;
	end

	// Build the answer in the view that the request's attribute asks for
	always_comb begin
		rsp_nxt.valid = s1_r.valid;
		rsp_nxt.rdata = 8'h00;
		if (s1_r.valid && !s1_r.write) begin
			unique case (s1_r.tgt)
				TGT_PRIO: begin
					if (s1_r.secure) begin
						rsp_nxt.rdata = mem_rdata;
					end else if (s1_grp_r) begin
						rsp_nxt.rdata = store_to_ns(mem_rdata);
					end
				end
				TGT_GROUP: begin
					rsp_nxt.rdata = {7'h00, s1_r.secure & s1_grp_r};
				end
				TGT_PMR: begin
					if (s1_r.secure) begin
						rsp_nxt.rdata = pmr_r;
					end else if (pmr_r[7]) begin
						rsp_nxt.rdata = store_to_ns(pmr_r);
					end
				end
				TGT_RPR: begin
					if (s1_r.secure) begin
						rsp_nxt.rdata = s1_rpr_r & PRIO_MASK;
					end else if (s1_rpr_r[7]) begin
						rsp_nxt.rdata = store_to_ns(s1_rpr_r);
					end
				end
			endcase
		end
	end

	// Registers only; reset leaves everything in group 0 and the mask at zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			grp_r <= GRP_RST;
			pmr_r <= PMR_RST;
			s1_r <= '0;
			s1_grp_r <= 1'b0;
			s1_rpr_r <= 8'h00;
			rsp_r <= '0;
		end else begin
			grp_r <= grp_nxt;
			pmr_r <= pmr_nxt;
			s1_r <= s1_nxt;
			s1_grp_r <= s1_grp_nxt;
			s1_rpr_r <= s1_rpr_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	assign rsp = rsp_r;
	assign prio_mask = pmr_r;
	assign irq_group = grp_r;

	// Checks on the translation, all on sys_clk
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_wr_prio(logic sec);
		req.valid && req.write && (req.tgt == TGT_PRIO) && (req.secure == sec);
	endsequence

	sequence s_rd_same(logic sec);
		req.valid && !req.write && (req.tgt == TGT_PRIO) && (req.secure == sec)
			&& (req.idx == $past(req.idx));
	endsequence

	property p_sec_roundtrip;
		s_wr_prio(1'b1) ##1 s_rd_same(1'b1)
			|-> ##2 (rsp_r.rdata == ($past(req.wdata, 3) & PRIO_MASK));
	endproperty
	a_sec_roundtrip: assert property (p_sec_roundtrip)
		else $error("secure priority read-back differs from masked write");

	property p_ns_roundtrip;
		(s_wr_prio(1'b0) and wr_g1) ##1 s_rd_same(1'b0)
			|-> ##2 (rsp_r.rdata == ($past(req.wdata, 3) & NS_MASK));
	endproperty
	a_ns_roundtrip: assert property (p_ns_roundtrip)
		else $error("non-secure group 1 read-back wrong");

	property p_ns_sets_top;
		(s_wr_prio(1'b0) and wr_g1) ##1 s_rd_same(1'b1) |-> ##2 rsp_r.rdata[7];
	endproperty
	a_ns_sets_top: assert property (p_ns_sets_top)
		else $error("non-secure write left top bit clear");

	property p_sec_clear_top;
		(s_wr_prio(1'b1) and !req.wdata[7]) ##1 s_rd_same(1'b1) |-> ##2 !rsp_r.rdata[7];
	endproperty
	a_sec_clear_top: assert property (p_sec_clear_top)
		else $error("secure write of clear top bit not kept");

	property p_g0_hidden;
		req.valid && !req.write && !req.secure && (req.tgt == TGT_PRIO) && !wr_g1
			|-> ##2 (rsp_r.valid && (rsp_r.rdata == 8'h00));
	endproperty
	a_g0_hidden: assert property (p_g0_hidden)
		else $error("group 0 priority visible to non-secure read");

	property p_pmr_hidden;
		req.valid && !req.write && !req.secure && (req.tgt == TGT_PMR) && !pmr_r[7]
			|-> ##2 (rsp_r.rdata == 8'h00);
	endproperty
	a_pmr_hidden: assert property (p_pmr_hidden)
		else $error("low mask visible to non-secure read");

	property p_pmr_wi;
		req.valid && req.write && !req.secure && (req.tgt == TGT_PMR) && !pmr_r[7]
			|=> $stable(pmr_r);
	endproperty
	a_pmr_wi: assert property (p_pmr_wi)
		else $error("non-secure write changed low mask");

	property p_rpr_hidden;
		req.valid && !req.write && !req.secure && (req.tgt == TGT_RPR) && !run_prio[7]
			|-> ##2 (rsp_r.rdata == 8'h00);
	endproperty
	a_rpr_hidden: assert property (p_rpr_hidden)
		else $error("low running priority visible to non-secure read");

	property p_low_zero;
		rsp_r.valid |-> ((rsp_r.rdata & ~PRIO_MASK & 8'hfe) == 8'h00);
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("unimplemented priority bits read non-zero");

	// Back-to-back requests are legal, so only the edge two cycles on is pinned
	property p_answer_timing;
		req.valid |-> ##2 rsp_r.valid;
	endproperty
	a_answer_timing: assert property (p_answer_timing)
		else $error("answer not two cycles after request");

	property p_no_spurious;
		!req.valid |-> ##2 !rsp_r.valid;
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("answer without a request two cycles before");

endmodule

// *** verification/cpu_access_model.sv ***
// Model of a processor core issuing single register accesses to the priority view block.
// Assumes the block answers in the second cycle after taking a request.
`timescale 1ns/1ps
module cpu_access_model (
	input wire logic sys_clk,
	output prio_view_pkg::access_req_t req,
	input wire prio_view_pkg::access_rsp_t rsp
);
	import prio_view_pkg::*;

	// Idle bus until the first access
	initial begin
		req = '0;
	end

	// Launch after an edge, hold through the taking edge, sample the answer in its cycle
	task automatic access(input logic sec, input logic wr, input target_t tgt,
		input logic [IDX_W-1:0] idx, input logic [7:0] wd, output access_rsp_t got);
		@(posedge sys_clk);
		#1;
		req = '{valid: 1'b1, write: wr, secure: sec, tgt: tgt, idx: idx, wdata: wd};
		@(posedge sys_clk);
		#1;
		// Released fields carry inverted junk, so a stale field is never mistaken for live
		req = '{valid: 1'b0, write: ~wr, secure: ~sec, tgt: target_t'(~tgt), idx: ~idx,
			wdata: ~wd};
		@(posedge sys_clk);
		#1;
		got = rsp;
	endtask

	// Write then read of one field in back-to-back cycles; the read must see the write
	task automatic access_pair(input logic ws, input logic rs, input target_t tgt,
		input logic [IDX_W-1:0] idx, input logic [7:0] wd, output access_rsp_t got_w,
		output access_rsp_t got_r);
		@(posedge sys_clk);
		#1;
		req = '{valid: 1'b1, write: 1'b1, secure: ws, tgt: tgt, idx: idx, wdata: wd};
		@(posedge sys_clk);
		#1;
		req = '{valid: 1'b1, write: 1'b0, secure: rs, tgt: tgt, idx: idx, wdata: ~wd};
		@(posedge sys_clk);
		#1;
		got_w = rsp;
		req = '{valid: 1'b0, write: 1'b1, secure: ~rs, tgt: target_t'(~tgt), idx: ~idx,
			wdata: wd};
		@(posedge sys_clk);
		#1;
		got_r = rsp;
	endtask
endmodule

// *** verification/priority_secure_view_logic_tb.sv ***
// Self-checking bench for the priority view block: corner accesses, then random ones.
// Assumes the processor model drives every request; expectations come from shadow state.
`timescale 1ns/1ps
module priority_secure_view_logic_tb;
	import prio_view_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] run_prio = 8'h00;
	access_req_t req;
	access_rsp_t rsp;
	logic [7:0] prio_mask;
	logic [NUM_IRQ-1:0] irq_group;
	logic [7:0] prio_sh [NUM_IRQ];
	logic [NUM_IRQ-1:0] grp_sh = GRP_RST;
	logic [7:0] pmr_sh = PMR_RST;
	int failures = 0;
	int total_checks = 0;

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	priority_secure_view_logic dut (.sys_clk(sys_clk), .srst(srst), .req(req),
		.run_prio(run_prio), .rsp(rsp), .prio_mask(prio_mask), .irq_group(irq_group));
	cpu_access_model cpu (.sys_clk(sys_clk), .req(req), .rsp(rsp));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// Shifted view that a non-secure access sees of a stored byte
	function automatic logic [7:0] nsv(input logic [7:0] v);
		return {v[6:0], 1'b0} & NS_MASK;
	endfunction

	function automatic logic [7:0] exp_read(input logic s, input target_t t, input int i);
		case (t)
			TGT_PRIO: return s ? prio_sh[i] : (grp_sh[i] ? nsv(prio_sh[i]) : 8'h00);
			TGT_GROUP: return s ? {7'h00, grp_sh[i]} : 8'h00;
			TGT_PMR: return s ? pmr_sh : (pmr_sh[7] ? nsv(pmr_sh) : 8'h00);
			default: return s ? (run_prio & PRIO_MASK) : (run_prio[7] ? nsv(run_prio) : 8'h00);
		endcase
	endfunction

	// Non-secure writes land shifted with the top bit set; hidden places ignore them
	task automatic shadow_write(input logic s, input target_t t, input int i, input logic [7:0] w);
		logic [7:0] nw;
		nw = {1'b1, w[7:1]} & PRIO_MASK;
		if (t == TGT_PRIO && (s || grp_sh[i])) begin
			prio_sh[i] = s ? (w & PRIO_MASK) : nw;
		end
		if (t == TGT_GROUP && s) begin
			grp_sh[i] = w[0];
		end
		if (t == TGT_PMR && (s || pmr_sh[7])) begin
			pmr_sh = s ? (w & PRIO_MASK) : nw;
		end
	endtask

	// One access with every visible effect compared
	task automatic op(input logic s, input logic wr, input target_t t, input int i,
		input logic [7:0] w);
		access_rsp_t got;
		logic [7:0] exp;
		exp = wr ? 8'h00 : exp_read(s, t, i);
		cpu.access(s, wr, t, IDX_W'(i), w, got);
		if (wr) begin
			shadow_write(s, t, i, w);
		end
		check("rsp.valid", got.valid, 1'b1);
		check("rsp.rdata", got.rdata, exp);
		check("prio_mask", prio_mask, pmr_sh);
		check("irq_group", irq_group, grp_sh);
	endtask

	// Write then read of the same field with no gap between the two requests
	task automatic wr_rd(input logic ws, input logic rs, input target_t t, input int i,
		input logic [7:0] w);
		access_rsp_t gw;
		access_rsp_t gr;
		logic [7:0] exp;
		cpu.access_pair(ws, rs, t, IDX_W'(i), w, gw, gr);
		shadow_write(ws, t, i, w);
		exp = exp_read(rs, t, i);
		check("rsp.valid", gw.valid, 1'b1);
		check("rsp.rdata", gw.rdata, 8'h00);
		check("rsp.valid", gr.valid, 1'b1);
		check("rsp.rdata", gr.rdata, exp);
		check("prio_mask", prio_mask, pmr_sh);
		check("irq_group", irq_group, grp_sh);
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard, far beyond the roughly 1500 cycles the tests need
	initial begin
		#1000000;
		failures++;
		finish_test();
	end

	// Main sequence
	initial begin
		void'($urandom(72));
		repeat (2) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		check("prio_mask", prio_mask, PMR_RST);
		check("irq_group", irq_group, GRP_RST);
		$display("test reset done");
		// Storage is not reset, so every field gets a known value first
		for (int i = 0; i < NUM_IRQ; i++) begin
			op(1'b1, 1'b1, TGT_PRIO, i, 8'(i * 8));
		end
		op(1'b1, 1'b1, TGT_GROUP, 1, 8'h01);
		op(1'b0, 1'b1, TGT_GROUP, 2, 8'h01);
		// Range probe; nothing in the bench raises the interrupt meanwhile
		op(1'b1, 1'b1, TGT_PRIO, 1, 8'hff);
		op(1'b1, 1'b0, TGT_PRIO, 1, 8'h00);
		op(1'b0, 1'b1, TGT_PRIO, 1, 8'hff);
		op(1'b0, 1'b0, TGT_PRIO, 1, 8'h00);
		op(1'b1, 1'b1, TGT_PRIO, 1, 8'h38);
		op(1'b0, 1'b0, TGT_PRIO, 1, 8'h00);
		op(1'b0, 1'b1, TGT_PRIO, 1, 8'h20);
		op(1'b1, 1'b0, TGT_PRIO, 1, 8'h00);
		op(1'b0, 1'b1, TGT_PRIO, 2, 8'hff);
		op(1'b0, 1'b0, TGT_PRIO, 2, 8'h00);
		op(1'b1, 1'b0, TGT_PRIO, 2, 8'h00);
		op(1'b0, 1'b1, TGT_PMR, 0, 8'hff);
		op(1'b1, 1'b1, TGT_PMR, 0, 8'hc8);
		op(1'b0, 1'b1, TGT_PMR, 0, 8'h40);
		op(1'b0, 1'b0, TGT_PMR, 0, 8'h00);
		op(1'b1, 1'b1, TGT_RPR, 0, 8'hff);
		run_prio = 8'h7f;
		op(1'b0, 1'b0, TGT_RPR, 0, 8'h00);
		run_prio = 8'hc8;
		op(1'b0, 1'b0, TGT_RPR, 0, 8'h00);
		op(1'b1, 1'b0, TGT_RPR, 0, 8'h00);
		// Back-to-back write and read: the read sees the write of the cycle before
		wr_rd(1'b1, 1'b1, TGT_PRIO, 3, 8'h40);
		wr_rd(1'b1, 1'b1, TGT_PRIO, 1, 8'hb8);
		wr_rd(1'b0, 1'b0, TGT_PRIO, 1, 8'h6c);
		wr_rd(1'b0, 1'b1, TGT_PRIO, 1, 8'h00);
		wr_rd(1'b0, 1'b0, TGT_PRIO, 2, 8'hff);
		wr_rd(1'b0, 1'b0, TGT_PMR, 0, 8'h10);
		$display("test corners done");
		// Reset in mid-run: mask and groups go back, storage keeps its contents
		@(posedge sys_clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		grp_sh = GRP_RST;
		pmr_sh = PMR_RST;
		check("prio_mask", prio_mask, PMR_RST);
		check("irq_group", irq_group, GRP_RST);
		op(1'b0, 1'b0, TGT_PRIO, 1, 8'h00);
		op(1'b1, 1'b0, TGT_PRIO, 1, 8'h00);
		$display("test mid reset done");
		// Random mix of views, targets and data
		repeat (300) begin
			run_prio = 8'($urandom);
			op(1'($urandom), 1'($urandom), target_t'(2'($urandom)), int'(IDX_W'($urandom)),
				8'($urandom));
		end
		repeat (100) begin
			run_prio = 8'($urandom);
			wr_rd(1'($urandom), 1'($urandom), target_t'(2'($urandom)),
				int'(IDX_W'($urandom)), 8'($urandom));
		end
		$display("test random done");
		finish_test();
	end
endmodule
